// ===== include/ebh_params.svh
// Purpose: Timing counts and reset values of the bus hold hand-off
// Assumes: E is one mem_clock_in period, P is one mclk_i period
// Notes:   Counts of E are rising edges of the resynchronised memory clock
`ifndef EBH_PARAMS_SVH
`define EBH_PARAMS_SVH
`define EBH_FLOAT_MIN_E 4'h2
`define EBH_DRIVE_MIN_E 4'h2
`define EBH_DRIVE_MAX_E 4'h7
`define EBH_REQ_KEEP_E 4'h1
`define EBH_RST_MIN_P 4'h2
`define EBH_RST_MIN_E 4'h3
`define EBH_RST_MAX_P 4'h3
`define EBH_RST_MAX_E 4'h4
`define EBH_GRANT_N_RST 1'h1
`define EBH_OE_N_RST 1'h1
`define EBH_STRB_IDLE 3'h7
`define EBH_BOOT_RST 2'h0
`endif

// ===== include/ebh_pkg.sv
// Purpose: Types shared by the bus hold hand-off
// Assumes: Active-low chip selects, byte enables and strobes
// Notes:   Field order of ebh_bus_t matches the pin groups
package ebh_pkg;
   typedef enum logic [2:0] {
      EBH_ST_RESET,
      EBH_ST_OWN,
      EBH_ST_DRAIN,
      EBH_ST_FLOAT,
      EBH_ST_GRANTED,
      EBH_ST_RELEASE,
      EBH_ST_DRIVE
   } ebh_state_t;

   typedef struct packed {
      logic read_col_strobe;
      logic write_strobe;
      logic output_row_strobe;
   } ebh_strobe_t;

   typedef struct packed {
      logic [3:0] chip_select_n;
      logic [3:0] byte_lane_enable_n;
      logic [21:2] mem_addr;
      logic [31:0] mem_data;
   } ebh_bus_t;
endpackage

// ===== hw/ebh_arbiter.sv
// Purpose: Hands the external memory bus to an outside master and back
// Assumes: mclk_i is the CPU clock (P); mem_clock_in_i is sampled (E)
// Notes:   All pins leave from flip-flops; floating is bus_oe_n_o high
//
// Functional notes
// - Running memory accesses finish before the grant goes low; pending ones are held back.
// - While hold_disable is 1 the outside request is deferred without a grant.
// - The bus floats no sooner than two memory periods after the request falls.
// - The grant goes low within two memory periods of the bus floating.
// - The bus is driven again two to seven memory periods after the request rises.
// - The grant returns high within two memory periods of driving the bus again.
// - Chip selects, byte enables, data, address and the three strobes all float.
// - The pending indication changes only on rising edges of mem_clock_out.
// - The bus floats 2P+3E after reset falls and is driven by 3P+4E after it rises.
// - The memory clock is resynchronised between 2P+3E and 3P+4E after reset edges.
// - Boot configuration is taken from host_data[4:3] as reset rises.
// - In SDRAM accesses the strobes act as column strobe, write enable, row strobe.
`include "ebh_params.svh"

module ebh_arbiter
   import ebh_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic mem_clock_in_i,
   input wire logic dev_reset_n_i,
   input wire logic ext_bus_request_n_i,
   input wire logic hold_disable_i,
   input wire logic [1:0] host_data_cfg_i,
   input wire logic access_queued_i,
   input wire logic access_busy_i,
   input wire logic sdram_sel_i,
   input wire ebh_bus_t bus_drive_i,
   input wire ebh_strobe_t async_strb_i,
   input wire ebh_strobe_t sdram_strb_i,
   input wire logic [31:0] mem_data_i,
   output logic [31:0] mem_data_rd_o,
   output ebh_bus_t mem_bus_o,
   output ebh_strobe_t strobe_o,
   output logic bus_oe_n_o,
   output logic ext_bus_grant_n_o,
   output logic internal_access_pending_o,
   output logic mem_clock_out_o,
   output logic mem_clock_resync_o,
   output logic access_stall_o,
   output logic [1:0] boot_mode_o
);

   typedef struct packed {
      ebh_state_t fsm;
      logic [3:0] cnt;
      logic clk_s1;
      logic clk_s2;
      logic clk_d;
      logic rst_s1;
      logic rst_s2;
      logic rst_d;
      logic req_s1;
      logic req_s2;
      logic [1:0] hd_s1;
      logic [1:0] hd_s2;
      logic [31:0] rd_s1;
      logic [31:0] rd_s2;
      logic seq_on;
      logic [3:0] seq_e;
      logic resync;
      logic pend;
      logic grant_n;
      logic oe_n;
      logic stall;
      logic [1:0] boot;
      ebh_bus_t bus;
      ebh_strobe_t strb;
   } ebh_regs_t;

   ebh_regs_t st;
   ebh_regs_t next_st;
   logic tick;
   logic rst_edge;

   // Memory-clock edge as seen after the synchroniser
   assign tick = st.clk_s2 & ~st.clk_d;
   assign rst_edge = st.rst_s2 ^ st.rst_d;

   function automatic logic [3:0] ebh_inc(input logic [3:0] v, input logic en);
      ebh_inc = (en && v != 4'hf) ? v + 4'h1 : v;
   endfunction

   always_comb
   begin
      next_st = st;
      next_st.clk_s1 = mem_clock_in_i;
      next_st.clk_s2 = st.clk_s1;
      next_st.clk_d = st.clk_s2;
      next_st.rst_s1 = dev_reset_n_i;
      next_st.rst_s2 = st.rst_s1;
      next_st.rst_d = st.rst_s2;
      next_st.req_s1 = ext_bus_request_n_i;
      next_st.req_s2 = st.req_s1;
      next_st.hd_s1 = host_data_cfg_i;
      next_st.hd_s2 = st.hd_s1;
      next_st.rd_s1 = mem_data_i;
      next_st.rd_s2 = st.rd_s1;
      next_st.resync = 1'h0;
      next_st.cnt = ebh_inc(st.cnt, tick);

      // Pin values follow the memory interface; only the enable floats them
      next_st.bus = bus_drive_i;
      next_st.strb = sdram_sel_i ? sdram_strb_i : async_strb_i;
      if (!st.rst_s2)
      begin
         next_st.strb = ebh_strobe_t'(`EBH_STRB_IDLE);
      end

      if (tick)
      begin
         next_st.pend = access_queued_i & st.rst_s2;
      end

      // Boot straps share the reset synchroniser depth, so they line up
      if (st.rst_s2 && !st.rst_d)
      begin
         next_st.boot = st.hd_s2;
      end

      // Four E edges from the synced edge; the sync lag is the P part
      if (rst_edge)
      begin
         next_st.seq_on = 1'h1;
         next_st.seq_e = tick ? 4'h1 : 4'h0;
      end
      else if (st.seq_on)
      begin
         next_st.seq_e = ebh_inc(st.seq_e, tick);
         if (st.seq_e == `EBH_RST_MIN_E + 4'h1)
         begin
            next_st.seq_on = 1'h0;
            next_st.resync = 1'h1;
            next_st.cnt = 4'h0;
            if (!st.rst_s2)
            begin
               next_st.fsm = EBH_ST_RESET;
               next_st.oe_n = 1'h1;
               next_st.grant_n = 1'h1;
               next_st.stall = 1'h1;
            end
            else
            begin
               next_st.fsm = EBH_ST_OWN;
               next_st.oe_n = 1'h0;
               next_st.stall = 1'h0;
            end
         end
      end

      if (!st.seq_on && !rst_edge)
      begin
         case (st.fsm)
            EBH_ST_RESET:
            begin
               next_st.oe_n = 1'h1;
            end
            EBH_ST_OWN:
            begin
               if (!st.req_s2 && !hold_disable_i)
               begin
                  next_st.fsm = EBH_ST_DRAIN;
                  next_st.cnt = 4'h0;
               end
            end
            EBH_ST_DRAIN:
            begin
               // New accesses are held back, running ones finish
               next_st.stall = 1'h1;
               if (st.req_s2 || hold_disable_i)
               begin
                  next_st.fsm = EBH_ST_OWN;
                  next_st.stall = 1'h0;
               end
               else if (st.cnt > `EBH_FLOAT_MIN_E && st.stall &&
                        !access_busy_i)
               begin
                  next_st.fsm = EBH_ST_FLOAT;
                  next_st.oe_n = 1'h1;
               end
            end
            EBH_ST_FLOAT:
            begin
               next_st.fsm = EBH_ST_GRANTED;
               next_st.grant_n = 1'h0;
               next_st.cnt = 4'h0;
            end
            EBH_ST_GRANTED:
            begin
               // Request is only trusted after the hold time has passed
               if (st.req_s2 && st.cnt >= `EBH_REQ_KEEP_E)
               begin
                  next_st.fsm = EBH_ST_RELEASE;
                  next_st.cnt = 4'h0;
               end
            end
            EBH_ST_RELEASE:
            begin
               if (st.cnt > `EBH_DRIVE_MIN_E)
               begin
                  next_st.fsm = EBH_ST_DRIVE;
                  next_st.oe_n = 1'h0;
               end
            end
            EBH_ST_DRIVE:
            begin
               next_st.fsm = EBH_ST_OWN;
               next_st.grant_n = 1'h1;
               next_st.stall = 1'h0;
            end
            default:
            begin
               next_st.fsm = EBH_ST_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= '0;
         st.fsm <= EBH_ST_RESET;
         st.oe_n <= `EBH_OE_N_RST;
         st.grant_n <= `EBH_GRANT_N_RST;
         st.stall <= 1'h1;
         st.boot <= `EBH_BOOT_RST;
         st.strb <= `EBH_STRB_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign mem_data_rd_o = st.rd_s2;
   assign mem_bus_o = st.bus;
   assign strobe_o = st.strb;
   assign bus_oe_n_o = st.oe_n;
   assign ext_bus_grant_n_o = st.grant_n;
   assign internal_access_pending_o = st.pend;
   assign mem_clock_out_o = st.clk_d;
   assign mem_clock_resync_o = st.resync;
   assign access_stall_o = st.stall;
   assign boot_mode_o = st.boot;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_grant_idle: assert property (
      (st.fsm == EBH_ST_DRAIN && next_st.fsm == EBH_ST_FLOAT) |-> !access_busy_i)
      else $error("bus floated while an access was running");

   chk_hold_defer: assert property (
      (hold_disable_i && st.fsm == EBH_ST_OWN && !st.seq_on && !rst_edge)
      |=> st.fsm == EBH_ST_OWN && st.grant_n)
      else $error("grant path entered while hold disabled");

   chk_float_min: assert property (
      $rose(st.fsm == EBH_ST_FLOAT) |-> $past(st.cnt) >= 4'h3)
      else $error("bus floated before two memory periods");

   chk_grant_after: assert property (
      $rose(st.fsm == EBH_ST_FLOAT) |-> st.oe_n ##1 !st.grant_n)
      else $error("grant late after float");

   chk_drive_bound: assert property (
      st.fsm == EBH_ST_RELEASE |-> st.cnt <= `EBH_DRIVE_MAX_E)
      else $error("bus drive later than seven memory periods");

   chk_grant_return: assert property (
      $rose(st.fsm == EBH_ST_DRIVE) |-> !st.oe_n ##1 st.grant_n)
      else $error("grant not withdrawn after driving");

   chk_pend_edge: assert property (
      $changed(st.pend) |-> $rose(st.clk_d))
      else $error("pending changed off a memory clock edge");

   chk_strb_mux: assert property (
      (st.rst_s2 && sdram_sel_i) |=> st.strb == $past(sdram_strb_i))
      else $error("sdram strobes not routed");

   chk_boot_take: assert property (
      (st.rst_s2 && !st.rst_d) |=> st.boot == $past(st.hd_s2))
      else $error("boot straps not taken at reset release");

   chk_stall_grant: assert property (
      !st.grant_n |-> st.stall ##0 (st.oe_n || st.fsm == EBH_ST_DRIVE))
      else $error("accesses not held while bus granted");

   chk_reset_float: assert property (
      $fell(st.rst_s2) |-> !st.resync [*3])
      else $error("reset float before 2P");
endmodule

// ===== dv/ebh_ext_master.sv
// Purpose: Outside bus master that borrows the memory bus
// Assumes: want_i comes from the bench, mem_clock_i is the memory clock
// Notes:   Never lets go of the request before two memory edges past the grant
module ebh_ext_master (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic mem_clock_i,
   input wire logic want_i,
   input wire logic grant_n_i,
   output logic ext_bus_request_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] seen;
   // Two edges, since the first may come almost at once
   always_ff @(posedge mem_clock_i or negedge rst_n_i)
      if (!rst_n_i) seen <= 2'h0;
      else seen <= {seen[0], ~grant_n_i};
   always_ff @(posedge mclk_i or negedge rst_n_i)
      if (!rst_n_i) ext_bus_request_n_o <= 1'h1;
      else if (want_i) ext_bus_request_n_o <= 1'h0;
      else if (grant_n_i || seen[1]) ext_bus_request_n_o <= 1'h1;
endmodule

// ===== dv/test_ext_mem_bus_hold_handshake.sv
// Purpose: Self-checking bench of the bus hold hand-off
// Assumes: Memory clock of 40 ns, free running, phase apart from mclk_i
// Notes:   Edge counts are rising memory clock edges seen by the bench
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module test_ext_mem_bus_hold_handshake
   import ebh_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst_n = 0, mclk_in = 0, dev_rst_n = 1, want = 0, hold_dis = 0;
   logic queued = 0, busy = 0, sd_sel = 0;
   logic [1:0] cfg = 2'h2;
   ebh_bus_t bus_drv = '0;
   ebh_strobe_t a_strb = 3'h5, s_strb = 3'h2, strb;
   ebh_bus_t mbus;
   logic [31:0] rd;
   logic req_n, oe_n, grant_n, pend, mco, resync, stall;
   logic [1:0] boot;
   int fail_count = 0, total_checks = 0, medges = 0, resync_n = 0;
   ebh_arbiter ebh_arbiter_inst (.mclk_i(mclk), .rst_n_i(rst_n), .mem_clock_in_i(mclk_in),
      .dev_reset_n_i(dev_rst_n), .ext_bus_request_n_i(req_n), .hold_disable_i(hold_dis),
      .host_data_cfg_i(cfg), .access_queued_i(queued), .access_busy_i(busy),
      .sdram_sel_i(sd_sel), .bus_drive_i(bus_drv), .async_strb_i(a_strb),
      .sdram_strb_i(s_strb), .mem_data_i(bus_drv.mem_data), .mem_data_rd_o(rd),
      .mem_bus_o(mbus), .strobe_o(strb), .bus_oe_n_o(oe_n), .ext_bus_grant_n_o(grant_n),
      .internal_access_pending_o(pend), .mem_clock_out_o(mco), .mem_clock_resync_o(resync),
      .access_stall_o(stall), .boot_mode_o(boot));
   ebh_ext_master ebh_ext_master_inst (.mclk_i(mclk), .rst_n_i(rst_n), .mem_clock_i(mclk_in),
      .want_i(want), .grant_n_i(grant_n), .ext_bus_request_n_o(req_n));
   ////////////////////////////////////////////////////////////////////////////
   always #4 mclk = ~mclk;
   initial
   begin
      #3;
      forever #20 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) medges++;
   always @(posedge mclk) if (resync === 1'b1) resync_n++;
   logic pend_q = 0, mco_q = 0;
   // Pending may only move together with a rising memory clock output
   always @(negedge mclk)
   begin
      if (rst_n && pend !== pend_q) `CHK("pend_edge", 1'b1, mco & ~mco_q)
      pend_q = pend;
      mco_q = mco;
   end
   ////////////////////////////////////////////////////////////////////////////
   function logic pick(int w);
      case (w)
         0: pick = oe_n;
         1: pick = grant_n;
         default: pick = req_n;
      endcase
   endfunction
   task automatic wait_for(input int w, input logic v, output int e);
      int m0, k;
      m0 = medges;
      k = 0;
      while (pick(w) !== v && k < 400)
      begin
         @(negedge mclk);
         k++;
      end
      if (k >= 400) `CHK("wait", 1'b1, 1'b0)
      e = medges - m0;
   endtask
   task automatic hold_cycle(output int fl, gr, dr, ug);
      int e;
      want = 1;
      wait_for(2, 0, e);
      wait_for(0, 1, fl);
      wait_for(1, 0, gr);
      `CHK("stall_held", 1'b1, stall)
      want = 0;
      wait_for(2, 1, e);
      wait_for(0, 0, dr);
      wait_for(1, 1, ug);
   endtask
   task automatic t_reset();
      int e;
      realtime t0;
      `CHK("float_rst", 1'b1, oe_n)
      wait_for(0, 0, e);
      `CHK("boot", 2'h2, boot)
      // Held low far past 10P by the float wait below
      dev_rst_n = 0;
      t0 = $realtime;
      wait_for(0, 1, e);
      `CHK("float_min", 1'b1, $realtime - t0 >= 136.0)
      // Straps settle 2P ahead of the rising reset and stay after it
      cfg = 2'h1;
      repeat (2) @(negedge mclk);
      dev_rst_n = 1;
      t0 = $realtime;
      wait_for(0, 0, e);
      // 3P+4E plus the half period before the bench looks
      `CHK("drive_max", 1'b1, $realtime - t0 <= 188.0)
      `CHK("boot2", 2'h1, boot)
      // Pulse is counted at the edge after it appears
      @(negedge mclk);
      `CHK("resync", 3, resync_n)
   endtask
   task automatic t_paths();
      bus_drv = {4'he, 4'h3, 20'h5a5a5, 32'hdeadbeef};
      queued = 1;
      repeat (3) @(negedge mclk);
      `CHK("strb_async", 3'h5, strb)
      `CHK("bus", bus_drv, mbus)
      `CHK("rd", 32'hdeadbeef, rd)
      sd_sel = 1;
      repeat (20) @(negedge mclk);
      `CHK("strb_sdram", 3'h2, strb)
      `CHK("pend", 1'b1, pend)
      queued = 0;
   endtask
   task automatic t_hold();
      int fl, gr, dr, ug;
      hold_cycle(fl, gr, dr, ug);
      `CHK("float_e", 1'b1, fl >= 2)
      `CHK("grant_e", 1'b1, gr <= 2)
      `CHK("drive_e", 1'b1, dr >= 2 && dr <= 7)
      `CHK("ungrant_e", 1'b1, ug <= 2)
      `CHK("stall_free", 1'b0, stall)
   endtask
   task automatic t_defer(input logic hold_disable);
      int e;
      hold_dis = hold_disable;
      busy = ~hold_disable;
      queued = ~hold_disable;
      want = 1;
      repeat (60) @(negedge mclk);
      `CHK("no_grant", 1'b1, grant_n)
      `CHK("still_own", 1'b0, oe_n)
      hold_dis = 0;
      busy = 0;
      wait_for(1, 0, e);
      `CHK("late_grant", 1'b0, grant_n)
      want = 0;
      wait_for(1, 1, e);
      queued = 0;
   endtask
   task automatic close_out();
      if (fail_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(negedge mclk);
      rst_n = 1;
      t_reset();
      t_paths();
      t_hold();
      t_defer(1'b1);
      t_defer(1'b0);
      t_hold();
      close_out();
   end
   // Whole run is a few hundred cycles; this leaves ample margin
   initial
   begin
      #200us;
      fail_count++;
      close_out();
   end
endmodule
